// >>> common/prc_map.vh
// prc_map.vh: register offsets, field positions, codes and reset values
// for the power/reset/firmware command handler; definitions only.
`ifndef PRC_MAP_VH
`define PRC_MAP_VH

// ==========================================================
// register byte offsets on the apb bus
`define PRC_OFS_FEATURE    12'h000
`define PRC_OFS_CNT_LO     12'h004
`define PRC_OFS_CNT_HI     12'h008
`define PRC_OFS_TRK_LO     12'h00C
`define PRC_OFS_TRK_HI     12'h010
`define PRC_OFS_UNIT       12'h014
`define PRC_OFS_COMMAND    12'h018
`define PRC_OFS_ERROR      12'h01C
`define PRC_OFS_STATUS     12'h020
`define PRC_OFS_CONFIG     12'h024
`define PRC_OFS_DATA       12'h028

// ==========================================================
// field positions
`define PRC_ST_BSY         7
`define PRC_ST_DRDY        6
`define PRC_ST_DF          5
`define PRC_ST_DRQ         3
`define PRC_ST_ERR         0
`define PRC_ER_ABRT        2
`define PRC_UNIT_DEV       4
`define PRC_CFG_PM         0
`define PRC_CFG_PKT        1
`define PRC_CFG_DL         2
`define PRC_CFG_SUB_TMP    3
`define PRC_CFG_SUB_SAVE   4

// ==========================================================
// command codes, subcommands, power results
`define PRC_CMD_POWER      8'hE5
`define PRC_CMD_RESET      8'h08
`define PRC_CMD_DOWNLOAD   8'h92
`define PRC_SUB_TEMP       8'h01
`define PRC_SUB_SAVE       8'h07
`define PRC_PWR_STANDBY    8'h00
`define PRC_PWR_IDLE       8'h80
`define PRC_PWR_ACTIVE     8'hFF
`define PRC_PS_STANDBY     2'h0
`define PRC_PS_IDLE        2'h1

// ==========================================================
// reset values and timing
`define PRC_RST_STATUS     8'h40
`define PRC_RST_CONFIG     5'h1F
`define PRC_RST_BYTE       8'h00
`define PRC_SECT_WORDS     8'hFF
`define PRC_ABRT_VALUE     8'h04

`endif

// >>> rtl/prc_cmd_handler.v
// prc_cmd_handler.v: task-file command handler for power mode query,
// per-unit reset and firmware download, with an apb register port.
// assumes apb master on sys_clk_i, power state and fault from same clock.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "prc_map.vh"

module prc_cmd_handler #(
	parameter [7:0] DIAG_CODE = 8'h01, // diagnostic pass code
	parameter [7:0] SIG_CNT   = 8'h01, // signature bytes, arbitrary values
	parameter [7:0] SIG_POS   = 8'h01,
	parameter [7:0] SIG_TRK_L = 8'h5A,
	parameter [7:0] SIG_TRK_H = 8'hA5
) (
	// clock, reset, enable
	input  wire        sys_clk_i,
	input  wire        sys_rst_i,
	input  wire        ce_i,
	// apb slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// unit address strap pin
	input  wire        unit_addr_i,
	// device side status
	input  wire [1:0]  power_state_i,
	input  wire        fault_i,
	input  wire        fw_reject_i,
	// firmware payload and actions
	output reg  [15:0] fw_word_o,
	output reg         fw_word_valid_o,
	output reg         fw_apply_o,
	output reg         fw_retain_o,
	output reg         unit_reset_o
);

	// ==========================================================
	// states
	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_EXEC  = 2'h1;
	localparam [1:0] S_DATA  = 2'h2;
	localparam [1:0] S_DONE  = 2'h3;

	// address match used by both read and write decode
	function hit;
		input [11:0] a;
		input [11:0] o;
		begin
			hit = (a == o);
		end
	endfunction

	// retain decision, shared by the zero-count and last-word paths
	function retain_sel;
		input [7:0] f;
		begin
			retain_sel = (f == `PRC_SUB_SAVE);
		end
	endfunction

	// ==========================================================
	// registers
	reg  [7:0]  feat_reg;
	reg  [7:0]  cnt_lo_reg;
	reg  [7:0]  cnt_hi_reg;
	reg  [7:0]  trk_lo_reg;
	reg  [7:0]  trk_hi_reg;
	reg  [7:0]  unit_reg;
	reg  [7:0]  cmd_reg;
	reg  [7:0]  err_reg;
	reg  [4:0]  cfg_reg;
	reg         bsy_reg;
	reg         drdy_reg;
	reg         df_reg;
	reg         drq_reg;
	reg         errf_reg;
	reg  [1:0]  state_reg;
	reg  [15:0] sect_left_reg;
	reg  [7:0]  word_cnt_reg;
	reg         strap_s1_reg;
	reg         strap_s2_reg;

	wire        wr_en;
	wire        rd_en;
	wire [7:0]  status_byte;
	wire [7:0]  rst_status;
	wire        for_me;
	wire        sub_ok;
	reg  [7:0]  rd_byte;
	reg         rd_hit;

	// the strap is a pin: two flops before anyone looks at it
	// the strap may settle late, yet commands are not held off: for_me uses strap_s2_reg, zero after reset, at once
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
		end else if (ce_i) begin
			strap_s1_reg <= unit_addr_i;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// ==========================================================
	// apb decode; always ready, so each access ends in its first access cycle
	// ce_i low freezes every register, but reads still answer from the frozen state
	// register map, one byte per aligned word, upper read bits zero:
	//   000 feature_select, write only, reads zero
	//   004 count_low_or_result
	//   008 count_high_or_position
	//   00C track_low_byte
	//   010 track_high_byte
	//   014 unit_select, unit number in bit 4
	//   018 command_code, write only
	//   01C error_flags, read only
	//   020 completion_status, read only
	//   024 config: b0 power management, b1 packet set, b2 download,
	//       b3 subcommand 01h allowed, b4 subcommand 07h allowed
	//   028 download data, write only, word in bits 15:0
	assign wr_en     = psel_i & penable_i & pwrite_i & ce_i;
	assign rd_en     = psel_i & penable_i & ~pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~rd_hit;
	assign prdata_o  = rd_en ? {24'h000000, rd_byte} : 32'h00000000;

	// status layout: busy, ready, fault, zero, data request, zero, zero, error
	assign status_byte = {bsy_reg, drdy_reg, df_reg, 1'b0,
		drq_reg, 2'b00, errf_reg};

	// power-on status as a vector, so each flag takes its own bit of it
	assign rst_status = `PRC_RST_STATUS;

	// commands for the other unit on the cable are left alone
	// the unit byte written before the command names the target, not the command word
	assign for_me = (unit_reg[`PRC_UNIT_DEV] == strap_s2_reg);

	// only the two defined subcommands, each gated by its enable
	assign sub_ok = (feat_reg == `PRC_SUB_TEMP && cfg_reg[`PRC_CFG_SUB_TMP]) ||
		(feat_reg == `PRC_SUB_SAVE && cfg_reg[`PRC_CFG_SUB_SAVE]);

	// read mux, data and command ports read as zero
	always @* begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		if (hit(paddr_i, `PRC_OFS_FEATURE)) begin
			rd_byte = 8'h00;
		end else if (hit(paddr_i, `PRC_OFS_CNT_LO)) begin
			rd_byte = cnt_lo_reg;
		end else if (hit(paddr_i, `PRC_OFS_CNT_HI)) begin
			rd_byte = cnt_hi_reg;
		end else if (hit(paddr_i, `PRC_OFS_TRK_LO)) begin
			rd_byte = trk_lo_reg;
		end else if (hit(paddr_i, `PRC_OFS_TRK_HI)) begin
			rd_byte = trk_hi_reg;
		end else if (hit(paddr_i, `PRC_OFS_UNIT)) begin
			rd_byte = unit_reg;
		end else if (hit(paddr_i, `PRC_OFS_COMMAND)) begin
			rd_byte = 8'h00;
		end else if (hit(paddr_i, `PRC_OFS_ERROR)) begin
			rd_byte = err_reg;
		end else if (hit(paddr_i, `PRC_OFS_STATUS)) begin
			rd_byte = status_byte;
		end else if (hit(paddr_i, `PRC_OFS_CONFIG)) begin
			rd_byte = {3'b000, cfg_reg};
		end else if (hit(paddr_i, `PRC_OFS_DATA)) begin
			rd_byte = 8'h00;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// ==========================================================
	// task file, command sequencer and status
	// timeline of a command, E being the edge that takes the command write:
	//   E    busy rises, command latched, state exec
	//   E+1  results, error, status bits and unit byte written
	//   E+2  busy falls, so a status poll never sees stale results
	// a download with a nonzero count instead drops busy and raises data
	// request at E+1, and busy returns with the last word of the last sector
	// limitation: a refused command write stalls the sequencer for one cycle
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			feat_reg        <= `PRC_RST_BYTE;
			cnt_lo_reg      <= `PRC_RST_BYTE;
			cnt_hi_reg      <= `PRC_RST_BYTE;
			trk_lo_reg      <= `PRC_RST_BYTE;
			trk_hi_reg      <= `PRC_RST_BYTE;
			unit_reg        <= `PRC_RST_BYTE;
			cmd_reg         <= `PRC_RST_BYTE;
			err_reg         <= `PRC_RST_BYTE;
			cfg_reg         <= `PRC_RST_CONFIG;
			bsy_reg         <= rst_status[`PRC_ST_BSY];
			drdy_reg        <= rst_status[`PRC_ST_DRDY];
			df_reg          <= rst_status[`PRC_ST_DF];
			drq_reg         <= rst_status[`PRC_ST_DRQ];
			errf_reg        <= rst_status[`PRC_ST_ERR];
			state_reg       <= S_IDLE;
			sect_left_reg   <= 16'h0000;
			word_cnt_reg    <= 8'h00;
			fw_word_o       <= 16'h0000;
			fw_word_valid_o <= 1'b0;
			fw_apply_o      <= 1'b0;
			fw_retain_o     <= 1'b0;
			unit_reset_o    <= 1'b0;
		end else if (ce_i) begin
			fw_word_valid_o <= 1'b0;
			fw_apply_o      <= 1'b0;
			unit_reset_o    <= 1'b0;

			// task file inputs are locked while busy or moving data
			if (wr_en && !bsy_reg && !drq_reg) begin
				if (hit(paddr_i, `PRC_OFS_FEATURE))
					feat_reg <= pwdata_i[7:0];
				else if (hit(paddr_i, `PRC_OFS_CNT_LO))
					cnt_lo_reg <= pwdata_i[7:0];
				else if (hit(paddr_i, `PRC_OFS_CNT_HI))
					cnt_hi_reg <= pwdata_i[7:0];
				else if (hit(paddr_i, `PRC_OFS_TRK_LO))
					trk_lo_reg <= pwdata_i[7:0];
				else if (hit(paddr_i, `PRC_OFS_TRK_HI))
					trk_hi_reg <= pwdata_i[7:0];
				else if (hit(paddr_i, `PRC_OFS_UNIT))
					unit_reg <= pwdata_i[7:0];
				else if (hit(paddr_i, `PRC_OFS_CONFIG))
					cfg_reg <= pwdata_i[4:0];
			end

			// command write; the unit byte must already name this unit
			if (wr_en && hit(paddr_i, `PRC_OFS_COMMAND) && for_me) begin
				// unit reset is taken even while busy or in a data phase
				if (pwdata_i[7:0] == `PRC_CMD_RESET) begin
					// unsupported reset caught busy: treated like the idle case
					cmd_reg   <= pwdata_i[7:0];
					bsy_reg   <= 1'b1;
					drq_reg   <= 1'b0;
					state_reg <= S_EXEC;
				end else if (!bsy_reg && !drq_reg) begin
					cmd_reg   <= pwdata_i[7:0];
					bsy_reg   <= 1'b1;
					state_reg <= S_EXEC;
				end
			end else begin
				case (state_reg)
					S_IDLE: begin
						state_reg <= S_IDLE;
					end
					S_EXEC: begin
						// outputs written here, BSY drops in the next cycle, or at once when a download enters S_DATA
						state_reg <= S_DONE;
						drdy_reg  <= 1'b1;
						// only DEV survives in the unit byte of any output
						unit_reg  <= {3'b000, strap_s2_reg, 4'h0};
						if (cmd_reg == `PRC_CMD_POWER) begin
							// abort when power management is off
							if (!cfg_reg[`PRC_CFG_PM]) begin
								err_reg  <= `PRC_ABRT_VALUE;
								errf_reg <= 1'b1;
								df_reg   <= fault_i;
							end else begin
								err_reg  <= 8'h00;
								errf_reg <= 1'b0;
								df_reg   <= 1'b0;
								if (power_state_i == `PRC_PS_STANDBY)
									cnt_lo_reg <= `PRC_PWR_STANDBY;
								else if (power_state_i == `PRC_PS_IDLE)
									cnt_lo_reg <= `PRC_PWR_IDLE;
								else
									cnt_lo_reg <= `PRC_PWR_ACTIVE;
							end
						end else if (cmd_reg == `PRC_CMD_RESET &&
							cfg_reg[`PRC_CFG_PKT]) begin
							// reset this unit, diagnostic and signature
							unit_reset_o <= 1'b1;
							err_reg      <= DIAG_CODE;
							cnt_lo_reg   <= SIG_CNT;
							cnt_hi_reg   <= SIG_POS;
							trk_lo_reg   <= SIG_TRK_L;
							trk_hi_reg   <= SIG_TRK_H;
							errf_reg     <= 1'b0;
							df_reg       <= 1'b0;
							drq_reg      <= 1'b0;
						end else if (cmd_reg == `PRC_CMD_DOWNLOAD &&
							cfg_reg[`PRC_CFG_DL] && !cfg_reg[`PRC_CFG_PKT] && sub_ok) begin
							// sixteen bit sector count, zero moves nothing
							if ({cnt_hi_reg, cnt_lo_reg} == 16'h0000) begin
								err_reg     <= 8'h00;
								errf_reg    <= 1'b0;
								df_reg      <= 1'b0;
								fw_apply_o  <= 1'b1;
								fw_retain_o <= retain_sel(feat_reg);
							end else begin
								sect_left_reg <= {cnt_hi_reg, cnt_lo_reg};
								word_cnt_reg  <= 8'h00;
								drq_reg       <= 1'b1;
								bsy_reg       <= 1'b0;
								state_reg     <= S_DATA;
							end
						end else begin
							err_reg  <= `PRC_ABRT_VALUE;
							errf_reg <= 1'b1;
							df_reg   <= fault_i;
						end
					end
					S_DATA: begin
						// whole sectors of 256 words, one word per data write
						if (wr_en && hit(paddr_i, `PRC_OFS_DATA)) begin
							fw_word_o       <= pwdata_i[15:0];
							fw_word_valid_o <= 1'b1;
							word_cnt_reg    <= word_cnt_reg + 8'h01;
							if (word_cnt_reg == `PRC_SECT_WORDS) begin
								sect_left_reg <= sect_left_reg - 16'h0001;
								if (sect_left_reg == 16'h0001) begin
									drq_reg   <= 1'b0;
									bsy_reg   <= 1'b1;
									state_reg <= S_DONE;
									// fw_reject_i is sampled only with the last word
									// payload rejected means abort
									if (fw_reject_i) begin
										err_reg  <= `PRC_ABRT_VALUE;
										errf_reg <= 1'b1;
										df_reg   <= fault_i;
									end else begin
										// apply now, keep when asked to
										err_reg     <= 8'h00;
										errf_reg    <= 1'b0;
										df_reg      <= 1'b0;
										fw_apply_o  <= 1'b1;
										fw_retain_o <= retain_sel(feat_reg);
									end
								end
							end
						end
					end
					S_DONE: begin
						// completion shown only after outputs settled
						bsy_reg   <= 1'b0;
						drq_reg   <= 1'b0;
						state_reg <= S_IDLE;
					end
					default: begin
						state_reg <= S_IDLE;
					end
				endcase
			end
		end
	end

endmodule // prc_cmd_handler

// >>> test/prc_cmd_handler_asserts.sv
// prc_cmd_handler_asserts.sv: port properties of the command handler.
// assumes it is bound to prc_cmd_handler and sees only its ports.
`timescale 1ns/1ps
`include "prc_map.vh"
module prc_cmd_handler_asserts (
	// clock, reset
	input logic        sys_clk_i,
	input logic        sys_rst_i,
	// apb
	input logic        psel_i,
	input logic        penable_i,
	input logic        pwrite_i,
	input logic [11:0] paddr_i,
	input logic [31:0] pwdata_i,
	input logic [31:0] prdata_o,
	input logic        pready_o,
	input logic        pslverr_o,
	// actions
	input logic [15:0] fw_word_o,
	input logic        fw_word_valid_o,
	input logic        fw_apply_o,
	input logic        unit_reset_o
);
	// ==========================================================
	// decoded bus events
	wire acc = psel_i && penable_i;
	wire mapped = paddr_i <= `PRC_OFS_DATA && paddr_i[1:0] == 2'b00;
	wire c8 = acc && pwrite_i && paddr_i == `PRC_OFS_COMMAND && pwdata_i[7:0] == `PRC_CMD_RESET;
	wire wd = acc && pwrite_i && paddr_i == `PRC_OFS_DATA;
	wire st = acc && !pwrite_i && paddr_i == `PRC_OFS_STATUS;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// properties
	chk_access_ready: assert property (acc |-> pready_o)
		else $error("no ready in access");
	chk_unmapped_flag: assert property (acc && !mapped |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not flagged");
	chk_mapped_clean: assert property (acc && mapped |-> !pslverr_o)
		else $error("mapped access flagged");
	chk_read_idle: assert property (!(acc && !pwrite_i) |-> prdata_o == 32'h0)
		else $error("read data outside read");
	chk_done_ready: assert property (st && !prdata_o[7] && !prdata_o[3] |-> prdata_o[6] &&
		(prdata_o[0] || !prdata_o[5])) else $error("completion without ready or with fault");
	chk_reset_cause: assert property (unit_reset_o |-> $past(c8) || $past(c8, 2))
		else $error("unit reset without command");
	chk_reset_pulse: assert property (unit_reset_o |=> !unit_reset_o)
		else $error("unit reset too long");
	chk_word_follows: assert property (fw_word_valid_o |-> $past(wd) &&
		fw_word_o == $past(pwdata_i[15:0])) else $error("payload word wrong");
	chk_apply_pulse: assert property (fw_apply_o |=> !fw_apply_o)
		else $error("apply too long");
	cover property (unit_reset_o);
	cover property (fw_apply_o);
	cover property (acc && pslverr_o);
endmodule // prc_cmd_handler_asserts

// >>> test/prc_host_model.sv
// prc_host_model.sv: apb master standing in for the host adapter.
// assumes one clock; the bench top calls xfer for every bus cycle.
`timescale 1ns/1ps
module prc_host_model (
	// clock
	input  logic        sys_clk_i,
	// apb request
	output logic        psel_o,
	output logic        penable_o,
	output logic        pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o,
	// apb answer
	input  logic [31:0] prdata_i,
	input  logic        pready_i,
	input  logic        pslverr_i
);
	// ==========================================================
	// bus cycle: request held until pready seen high at an edge
	initial begin
		{psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk_i);
		psel_o    <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o  <= w;
		paddr_o   <= a;
		pwdata_o  <= d;
		@(posedge sys_clk_i);
		penable_o <= 1'b1;
		do @(posedge sys_clk_i); while (pready_i !== 1'b1);
		// answer taken at the same edge, released only afterwards
		q = prdata_i;
		e = pslverr_i;
		psel_o    <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule // prc_host_model

// >>> test/tb.sv
// tb.sv: self-checking bench for the command handler.
// assumes the host model drives apb; status inputs are driven here.
`timescale 1ns/1ps
`include "prc_map.vh"
module tb;
	// ==========================================================
	// signals and counters
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [1:0]  power_state_i = 2'h0;
	logic        fault_i = 1'b0;
	logic        fw_reject_i = 1'b0;
	logic        ce_i = 1'b1;
	logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic        fw_word_valid_o, fw_apply_o, fw_retain_o, unit_reset_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	logic [15:0] fw_word_o;
	logic        e;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          n_app = 0;
	int          n_rst = 0;
	logic [15:0] words[$];
	logic [7:0]  ps_exp[4] = '{8'h00, 8'h80, 8'hFF, 8'hFF};
	int          ps;

	initial forever #50 sys_clk_i = ~sys_clk_i;

	prc_host_model prc_host_model_i (.sys_clk_i, .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o),
		.pready_i(pready_o), .pslverr_i(pslverr_o));
	prc_cmd_handler prc_cmd_handler_i (.sys_clk_i, .sys_rst_i, .ce_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.unit_addr_i(1'b1), .power_state_i, .fault_i, .fw_reject_i, .fw_word_o,
		.fw_word_valid_o, .fw_apply_o, .fw_retain_o, .unit_reset_o);

	// ==========================================================
	// monitor: payload words against the queue, pulse counts, timeout
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (fw_word_valid_o === 1'b1) chk(fw_word_o, words.pop_front(), "word");
		if (fw_apply_o === 1'b1) n_app <= n_app + 1;
		if (unit_reset_o === 1'b1) n_rst <= n_rst + 1;
		if (cyc == 20000) begin
			chk(0, 1, "timeout");
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		prc_host_model_i.xfer(1'b1, a, {24'h0, d}, q, e);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] x, input string m);
		prc_host_model_i.xfer(1'b0, a, 32'h0, q, e);
		chk(q, {24'h0, x}, m);
	endtask
	// polls status until busy and data request match
	task automatic wait_st(input logic [7:0] v);
		do prc_host_model_i.xfer(1'b0, `PRC_OFS_STATUS, 32'h0, q, e);
		while ((q[7:0] & 8'h88) !== v);
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(`PRC_OFS_COMMAND, c);
		wait_st(8'h00);
	endtask
	task automatic res(input logic [7:0] er, input logic [7:0] st, input string m);
		rd_chk(`PRC_OFS_ERROR, er, m);
		rd_chk(`PRC_OFS_STATUS, st, m);
		rd_chk(`PRC_OFS_UNIT, 8'h10, m);
	endtask
	// one download: subcommand, sector count, reject level
	task automatic dl(input logic [7:0] sub, input logic [15:0] n, input logic rej);
		int a0;
		logic ok;
		logic [15:0] w;
		a0 = n_app;
		ok = (sub == `PRC_SUB_TEMP || sub == `PRC_SUB_SAVE) && !rej;
		fw_reject_i <= rej;
		wr(`PRC_OFS_FEATURE, sub);
		wr(`PRC_OFS_CNT_LO, n[7:0]);
		wr(`PRC_OFS_CNT_HI, n[15:8]);
		wr(`PRC_OFS_TRK_LO, 8'h00);
		wr(`PRC_OFS_TRK_HI, 8'h00);
		wr(`PRC_OFS_COMMAND, `PRC_CMD_DOWNLOAD);
		if (n != 0 && (ok || rej)) begin
			wait_st(8'h08);
			repeat (int'(n) * 256) begin
				w = 16'($urandom);
				words.push_back(w);
				prc_host_model_i.xfer(1'b1, `PRC_OFS_DATA, {16'h0, w}, q, e);
			end
		end
		wait_st(8'h00);
		res(ok ? 8'h00 : 8'h04, ok ? 8'h40 : 8'h41, "download");
		chk(n_app - a0, ok, "apply");
		if (ok) chk(fw_retain_o, sub == `PRC_SUB_SAVE, "retain");
		chk(words.size(), 0, "words left");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h4717));
		repeat (20) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		rd_chk(`PRC_OFS_STATUS, 8'h40, "rst status");
		rd_chk(`PRC_OFS_CONFIG, 8'h1F, "rst config");
		rd_chk(`PRC_OFS_CNT_LO, 8'h00, "rst count");
		// a write while the enable is low must not land
		ce_i <= 1'b0;
		wr(`PRC_OFS_CNT_LO, 8'h3C);
		ce_i <= 1'b1;
		rd_chk(`PRC_OFS_CNT_LO, 8'h00, "frozen");
		$display("reset test done");
		wr(`PRC_OFS_UNIT, 8'h10);
		repeat (8) begin
			ps = $urandom_range(3);
			power_state_i <= 2'(ps);
			cmd(`PRC_CMD_POWER);
			rd_chk(`PRC_OFS_CNT_LO, ps_exp[ps], "power");
			res(8'h00, 8'h40, "power");
		end
		wr(`PRC_OFS_CONFIG, 8'h1E);
		fault_i <= 1'($urandom_range(1));
		cmd(`PRC_CMD_POWER);
		res(`PRC_ABRT_VALUE, fault_i ? 8'h61 : 8'h41, "power abort");
		$display("power test done");
		fault_i <= 1'b0;
		wr(`PRC_OFS_CONFIG, 8'h1F);
		cmd(`PRC_CMD_RESET);
		res(8'h01, 8'h40, "unit reset");
		rd_chk(`PRC_OFS_TRK_HI, 8'hA5, "signature");
		chk(n_rst, 1, "reset pulse");
		wr(`PRC_OFS_CONFIG, 8'h1D);
		cmd(`PRC_CMD_RESET);
		res(8'h04, 8'h41, "reset abort");
		wr(`PRC_OFS_CONFIG, 8'h1F);
		wr(`PRC_OFS_UNIT, 8'h00);
		cmd(`PRC_CMD_RESET);
		chk(n_rst, 1, "other unit");
		wr(`PRC_OFS_UNIT, 8'h10);
		$display("unit reset test done");
		wr(`PRC_OFS_FEATURE, `PRC_SUB_TEMP);
		wr(`PRC_OFS_CNT_LO, 8'h00);
		wr(`PRC_OFS_CNT_HI, 8'h00);
		cmd(`PRC_CMD_DOWNLOAD);
		res(8'h04, 8'h41, "packet set");
		wr(`PRC_OFS_CONFIG, 8'h1D);
		dl(`PRC_SUB_TEMP, 16'h0001, 1'b0);
		dl(`PRC_SUB_SAVE, 16'h0000, 1'b0);
		dl(8'h03, 16'h0001, 1'b0);
		dl(`PRC_SUB_SAVE, 16'h0001, 1'b1);
		// a reset written in the data phase is taken; without the packet set it aborts
		wr(`PRC_OFS_COMMAND, `PRC_CMD_DOWNLOAD);
		wait_st(8'h08);
		cmd(`PRC_CMD_RESET);
		res(8'h04, 8'h41, "reset in data phase");
		chk(n_rst, 1, "reset in data phase");
		$display("download test done");
		prc_host_model_i.xfer(1'b0, 12'h02C, 32'h0, q, e);
		chk(e, 1'b1, "unmapped");
		$display("bus test done");
		end_sim();
	end
endmodule // tb

bind prc_cmd_handler prc_cmd_handler_asserts chk_i (.sys_clk_i, .sys_rst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
	.fw_word_o, .fw_word_valid_o, .fw_apply_o, .unit_reset_o);
